// *** hw/rpt_defs.svh ***
// Register offsets, reset values, field positions and timing counts for the RGB panel timing block.
// Assumes a 10 MHz system clock and an APB slave with 32-bit data.
`ifndef RPT_DEFS_SVH
`define RPT_DEFS_SVH

`define RPT_ADDR_W 8
`define RPT_OFF_PCLK_DIV 8'h00
`define RPT_OFF_PCLK_EDGE 8'h04
`define RPT_OFF_SKEW 8'h08
`define RPT_OFF_DITHER 8'h0c
`define RPT_OFF_BIT_WIDTH 8'h10
`define RPT_OFF_PIN_ARR 8'h14
`define RPT_OFF_H_TOTAL 8'h18
`define RPT_OFF_H_SIZE 8'h1c
`define RPT_OFF_H_OFFSET 8'h20
`define RPT_OFF_H_SYNC0 8'h24
`define RPT_OFF_H_SYNC1 8'h28
`define RPT_OFF_V_TOTAL 8'h2c
`define RPT_OFF_V_SIZE 8'h30
`define RPT_OFF_V_OFFSET 8'h34
`define RPT_OFF_V_SYNC0 8'h38
`define RPT_OFF_V_SYNC1 8'h3c
`define RPT_OFF_LEGACY_PIN 8'h40
`define RPT_OFF_EXT_PIN 8'h44
`define RPT_OFF_BL_FREQ 8'h48
`define RPT_OFF_BL_DUTY 8'h4c
`define RPT_OFF_STATUS 8'h50

`define RPT_RST_BIT_WIDTH 12'h888
`define RPT_RST_BL_FREQ 14'h00fa
`define RPT_RST_BL_DUTY 8'h80

`define RPT_LEGACY_PANEL_BIT 7
`define RPT_EXT_PANEL_BIT 15
`define RPT_ARR_REVERSE 0
`define RPT_ARR_SWAP 1
`define RPT_ARR_RIGHT 2
`define RPT_ARR_ROTATE 3

`define RPT_CLK_HZ 10000000
`define RPT_BL_FREQ_MIN 14'h00fa
`define RPT_BL_FREQ_MAX 14'h2710
`define RPT_BL_DUTY_FULL 128
`define RPT_BL_DUTY_STEP (`RPT_CLK_HZ / `RPT_BL_DUTY_FULL)

`endif

// *** hw/rpt_pkg.sv ***
// Types shared by the RGB panel timing block and its backlight generator.
// Assumes nothing beyond the defs header.
package rpt_pkg;
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} rpt_rgb_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rpt_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rpt_apb_rsp_t;
endpackage

// *** hw/rpt_pwm.sv ***
// Backlight PWM generator, phase accumulator driven by the system clock.
// Assumes frequency and duty come from registers on the same clock.
`include "rpt_defs.svh"

module rpt_pwm (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Settings
	input wire logic [13:0] freq_i,
	input wire logic [7:0] duty_i,
	input wire logic panel_enable_i,
	// Pin
	output logic backlight_o
);
	import rpt_pkg::*;

	logic [23:0] acc_r;
	logic [23:0] acc_nxt;
	logic [13:0] freq_lim;
	logic [7:0] duty_lim;
	logic [31:0] thresh;

	// Out-of-range frequencies are clamped rather than refused
	always_comb begin
		freq_lim = freq_i;
		if (freq_i < `RPT_BL_FREQ_MIN)
			freq_lim = `RPT_BL_FREQ_MIN;
		else if (freq_i > `RPT_BL_FREQ_MAX)
			freq_lim = `RPT_BL_FREQ_MAX;
		duty_lim = (duty_i > 8'(`RPT_BL_DUTY_FULL)) ? 8'(`RPT_BL_DUTY_FULL) : duty_i;
		thresh = 32'(duty_lim) * 32'(`RPT_BL_DUTY_STEP);
	end

	// Accumulator wraps at the clock rate, so one wrap is one PWM period
	always_comb begin
		if (32'(acc_r) + 32'(freq_lim) >= 32'(`RPT_CLK_HZ))
			acc_nxt = 24'(32'(acc_r) + 32'(freq_lim) - 32'(`RPT_CLK_HZ));
		else
			acc_nxt = acc_r + 24'(freq_lim);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			acc_r <= 24'h000000;
		else if (ce_i)
			acc_r <= acc_nxt;
	end

	// Zero duty never passes, full duty always passes the compare
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			backlight_o <= 1'b0;
		else if (ce_i)
			backlight_o <= panel_enable_i && (32'(acc_r) < thresh);
	end
endmodule

// *** hw/rpt_panel.sv ***
// Parallel RGB panel output stage: pixel clock, sync/enable timing, colour path, backlight, panel enable.
// Assumes an APB master on sys_clk_i and a pixel source on the same clock that honours pixel_take_o.
// Behaviour
// - Divisor zero keeps pixel clock disabled
// - Pixel clock is system clock over divisor
// - Edge select chooses rising or falling edge
// - Skew off: all colours change together
// - Skew on: red early, blue late
// - Dither eight-bit colour to panel precision
// - Per-channel bit width, default eight each
// - Arrangement bit 0 reverses bit order
// - Arrangement bit 1 swaps red, blue
// - Bit 3 rotates; bit 2 picks direction
// - Horizontal settings are twelve-bit pixel counts
// - Vertical settings are twelve-bit line counts
// - Line lasts total; visible lasts width
// - Line sync from sync start to end
// - Frame lasts total lines; visible lines after offset
// - Frame sync from sync start to end
// - Backlight PWM between 250 and 10000 Hz
// - Duty 0 off, 128 on, proportional between
// - Panel enable low forces backlight low
// - Panel enable follows either control register bit
//
// Implementation choices: the APB register port and the address map.
`include "rpt_defs.svh"

module rpt_panel (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register bus
	input wire rpt_pkg::rpt_apb_req_t apb_req_i,
	output rpt_pkg::rpt_apb_rsp_t apb_rsp_o,
	// Pixel source
	input wire rpt_pkg::rpt_rgb_t pixel_i,
	output logic pixel_take_o,
	// Panel pins
	output logic pclk_o,
	output logic line_sync_o,
	output logic frame_sync_o,
	output logic data_enable_o,
	output rpt_pkg::rpt_rgb_t colour_pins_o,
	output logic panel_enable_out_o,
	output logic backlight_o
);
	import rpt_pkg::*;

	// Settings
	logic [9:0] pclk_div_r;
	logic pixel_clock_edge_select_r, colour_skew_enable_r, dither_enable_r;
	logic [11:0] channel_bit_width_r;
	logic [3:0] colour_pin_arrangement_r;
	logic [11:0] line_total_count_r, line_visible_width_r, line_blank_offset_r, line_sync_start_r, line_sync_end_r;
	logic [11:0] frame_total_lines_r, frame_visible_lines_r, frame_blank_offset_r;
	logic [11:0] frame_sync_start_r, frame_sync_end_r;
	logic [6:0] legacy_pin_rest_r;
	logic [14:0] ext_pin_rest_r;
	logic panel_enable_r;
	logic [13:0] backlight_frequency_r;
	logic [7:0] backlight_duty_r;

	// Bus decode
	logic wr_en, rd_hit;
	logic [31:0] rd_data;
	logic [7:0] addr;

	assign addr = apb_req_i.paddr;
	assign wr_en = ce_i && apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && addr[1:0] == 2'h0;

	// Register writes; one-cycle answer so pready only follows the enable
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pclk_div_r <= 10'h000;
			pixel_clock_edge_select_r <= 1'b0;
			colour_skew_enable_r <= 1'b0;
			dither_enable_r <= 1'b0;
			channel_bit_width_r <= `RPT_RST_BIT_WIDTH;
			colour_pin_arrangement_r <= 4'h0;
			line_total_count_r <= 12'h000;
			line_visible_width_r <= 12'h000;
			line_blank_offset_r <= 12'h000;
			line_sync_start_r <= 12'h000;
			line_sync_end_r <= 12'h000;
			frame_total_lines_r <= 12'h000;
			frame_visible_lines_r <= 12'h000;
			frame_blank_offset_r <= 12'h000;
			frame_sync_start_r <= 12'h000;
			frame_sync_end_r <= 12'h000;
			legacy_pin_rest_r <= 7'h00;
			ext_pin_rest_r <= 15'h0000;
			panel_enable_r <= 1'b0;
			backlight_frequency_r <= `RPT_RST_BL_FREQ;
			backlight_duty_r <= `RPT_RST_BL_DUTY;
		end else if (wr_en) begin
			case (addr)
				`RPT_OFF_PCLK_DIV: pclk_div_r <= apb_req_i.pwdata[9:0];
				`RPT_OFF_PCLK_EDGE: pixel_clock_edge_select_r <= apb_req_i.pwdata[0];
				`RPT_OFF_SKEW: colour_skew_enable_r <= apb_req_i.pwdata[0];
				`RPT_OFF_DITHER: dither_enable_r <= apb_req_i.pwdata[0];
				`RPT_OFF_BIT_WIDTH: channel_bit_width_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_PIN_ARR: colour_pin_arrangement_r <= apb_req_i.pwdata[3:0];
				`RPT_OFF_H_TOTAL: line_total_count_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_H_SIZE: line_visible_width_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_H_OFFSET: line_blank_offset_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_H_SYNC0: line_sync_start_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_H_SYNC1: line_sync_end_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_V_TOTAL: frame_total_lines_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_V_SIZE: frame_visible_lines_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_V_OFFSET: frame_blank_offset_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_V_SYNC0: frame_sync_start_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_V_SYNC1: frame_sync_end_r <= apb_req_i.pwdata[11:0];
				`RPT_OFF_LEGACY_PIN: begin
					legacy_pin_rest_r <= apb_req_i.pwdata[6:0];
					panel_enable_r <= apb_req_i.pwdata[`RPT_LEGACY_PANEL_BIT];
				end
				`RPT_OFF_EXT_PIN: begin
					ext_pin_rest_r <= apb_req_i.pwdata[14:0];
					panel_enable_r <= apb_req_i.pwdata[`RPT_EXT_PANEL_BIT];
				end
				`RPT_OFF_BL_FREQ: backlight_frequency_r <= apb_req_i.pwdata[13:0];
				`RPT_OFF_BL_DUTY: backlight_duty_r <= apb_req_i.pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Timing counters, declared here for the status read
	logic [11:0] hcnt_r, vcnt_r;

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		case (addr)
			`RPT_OFF_PCLK_DIV: rd_data = {22'h000000, pclk_div_r};
			`RPT_OFF_PCLK_EDGE: rd_data = {31'h00000000, pixel_clock_edge_select_r};
			`RPT_OFF_SKEW: rd_data = {31'h00000000, colour_skew_enable_r};
			`RPT_OFF_DITHER: rd_data = {31'h00000000, dither_enable_r};
			`RPT_OFF_BIT_WIDTH: rd_data = {20'h00000, channel_bit_width_r};
			`RPT_OFF_PIN_ARR: rd_data = {28'h0000000, colour_pin_arrangement_r};
			`RPT_OFF_H_TOTAL: rd_data = {20'h00000, line_total_count_r};
			`RPT_OFF_H_SIZE: rd_data = {20'h00000, line_visible_width_r};
			`RPT_OFF_H_OFFSET: rd_data = {20'h00000, line_blank_offset_r};
			`RPT_OFF_H_SYNC0: rd_data = {20'h00000, line_sync_start_r};
			`RPT_OFF_H_SYNC1: rd_data = {20'h00000, line_sync_end_r};
			`RPT_OFF_V_TOTAL: rd_data = {20'h00000, frame_total_lines_r};
			`RPT_OFF_V_SIZE: rd_data = {20'h00000, frame_visible_lines_r};
			`RPT_OFF_V_OFFSET: rd_data = {20'h00000, frame_blank_offset_r};
			`RPT_OFF_V_SYNC0: rd_data = {20'h00000, frame_sync_start_r};
			`RPT_OFF_V_SYNC1: rd_data = {20'h00000, frame_sync_end_r};
			`RPT_OFF_LEGACY_PIN: rd_data = {24'h000000, panel_enable_r, legacy_pin_rest_r};
			`RPT_OFF_EXT_PIN: rd_data = {16'h0000, panel_enable_r, ext_pin_rest_r};
			`RPT_OFF_BL_FREQ: rd_data = {18'h00000, backlight_frequency_r};
			`RPT_OFF_BL_DUTY: rd_data = {24'h000000, backlight_duty_r};
			`RPT_OFF_STATUS: rd_data = {4'h0, vcnt_r, 4'h0, hcnt_r};
			default: rd_hit = 1'b0;
		endcase
		if (addr[1:0] != 2'h0)
			rd_hit = 1'b0;
	end

	// Unmapped or misaligned accesses answer with an error and zero data
	always_comb begin
		apb_rsp_o.pready = ce_i;
		apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && !rd_hit;
		apb_rsp_o.prdata = (apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite && rd_hit) ? rd_data
			: 32'h00000000;
	end

	// Pixel clock divider
	logic [9:0] pdiv_cnt_r, pdiv_cnt_nxt, pdiv_half;
	logic pix_tick, pclk_phase_r, pclk_is_sys;

	assign pix_tick = ce_i && pclk_div_r != 10'h000 && pdiv_cnt_r >= pclk_div_r - 10'h001;
	assign pdiv_cnt_nxt = pix_tick ? 10'h000 : pdiv_cnt_r + 10'h001;
	assign pdiv_half = 10'((11'(pclk_div_r) + 11'h001) >> 1);
	assign pclk_is_sys = pclk_div_r == 10'h001;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pdiv_cnt_r <= 10'h000;
		else if (ce_i)
			pdiv_cnt_r <= (pclk_div_r == 10'h000) ? 10'h000 : pdiv_cnt_nxt;
	end

	// Active half starts at the tick, so data changes ride the active edge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pclk_phase_r <= 1'b0;
		else if (ce_i)
			pclk_phase_r <= pclk_div_r != 10'h000 && pdiv_cnt_nxt < pdiv_half;
	end

	// Divide by one cannot come from a flop; the system clock is passed straight out
	assign pclk_o = (pclk_is_sys ? sys_clk_i : pclk_phase_r) ^ pixel_clock_edge_select_r;

	// Line and frame counters
	logic h_wrap, v_wrap, h_vis, v_vis, h_sync, v_sync;
	logic [12:0] h_vis_end, v_vis_end;

	assign h_wrap = 13'(hcnt_r) + 13'h0001 >= 13'(line_total_count_r);
	assign v_wrap = 13'(vcnt_r) + 13'h0001 >= 13'(frame_total_lines_r);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			hcnt_r <= 12'h000;
		else if (pix_tick)
			hcnt_r <= h_wrap ? 12'h000 : hcnt_r + 12'h001;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			vcnt_r <= 12'h000;
		else if (pix_tick && h_wrap)
			vcnt_r <= v_wrap ? 12'h000 : vcnt_r + 12'h001;
	end

	// Visible window follows the blanking offset; wide sums avoid wrap at 4095
	assign h_vis_end = 13'(line_blank_offset_r) + 13'(line_visible_width_r);
	assign v_vis_end = 13'(frame_blank_offset_r) + 13'(frame_visible_lines_r);
	assign h_vis = hcnt_r >= line_blank_offset_r && 13'(hcnt_r) < h_vis_end;
	assign v_vis = vcnt_r >= frame_blank_offset_r && 13'(vcnt_r) < v_vis_end;
	assign h_sync = hcnt_r >= line_sync_start_r && hcnt_r < line_sync_end_r;
	assign v_sync = vcnt_r >= frame_sync_start_r && vcnt_r < frame_sync_end_r;

	assign pixel_take_o = pix_tick && h_vis && v_vis;

	// Dither and width reduction, one lane per channel
	logic [1:0] bayer;
	rpt_rgb_t reduced;

	always_comb begin
		case ({vcnt_r[0], hcnt_r[0]})
			2'h0: bayer = 2'h0;
			2'h1: bayer = 2'h2;
			2'h2: bayer = 2'h3;
			default: bayer = 2'h1;
		endcase
	end

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_lane
			logic [3:0] width_raw;
			logic [3:0] width;
			logic [7:0] in_val;
			logic [7:0] keep_mask;
			logic [7:0] bias;
			logic [8:0] sum;
			logic [7:0] sat;

			// Red field sits lowest, but lane 0 is the blue byte
			assign width_raw = channel_bit_width_r[(2 - ch)*4 +: 4];
			// Zero or out-of-range width falls back to full precision
			assign width = (width_raw == 4'h0 || width_raw > 4'h8) ? 4'h8 : width_raw;
			assign in_val = pixel_i[ch*8 +: 8];
			assign keep_mask = 8'(16'hff00 >> width);
			// Bias is the Bayer fraction of one output step
			assign bias = dither_enable_r ? 8'({bayer, 6'h00} >> width) : 8'h00;
			assign sum = 9'(in_val) + 9'(bias);
			assign sat = sum[8] ? 8'hff : sum[7:0];
			assign reduced[ch*8 +: 8] = (h_vis && v_vis) ? (sat & keep_mask) : 8'h00;
		end
	endgenerate

	// Skew pipeline: green and controls always one pixel late
	rpt_rgb_t pipe1_r;
	rpt_rgb_t pipe2_r;
	rpt_rgb_t logical;
	logic de1_r;
	logic hs1_r;
	logic vs1_r;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pipe1_r <= '0;
			pipe2_r <= '0;
			de1_r <= 1'b0;
			hs1_r <= 1'b0;
			vs1_r <= 1'b0;
		end else if (pix_tick) begin
			pipe1_r <= reduced;
			pipe2_r <= pipe1_r;
			de1_r <= h_vis && v_vis;
			hs1_r <= h_sync;
			vs1_r <= v_sync;
		end
	end

	always_comb begin
		logical = pipe1_r;
		if (colour_skew_enable_r) begin
			logical.red = reduced.red;
			logical.blue = pipe2_r.blue;
		end
	end

	// Pin arrangement
	function automatic logic [7:0] rpt_rev8(input logic [7:0] v);
		logic [7:0] o;
		o = 8'h00;
		for (int i = 0; i < 8; i++)
			o[i] = v[7 - i];
		return o;
	endfunction

	rpt_rgb_t ordered;
	rpt_rgb_t arranged;

	always_comb begin
		ordered = logical;
		if (!colour_pin_arrangement_r[`RPT_ARR_ROTATE]) begin
			if (colour_pin_arrangement_r[`RPT_ARR_SWAP])
				ordered = '{red: logical.blue, green: logical.green, blue: logical.red};
		end else begin
			case (colour_pin_arrangement_r[2:1])
				2'h0: ordered = '{red: logical.blue, green: logical.red, blue: logical.green};
				2'h1: ordered = '{red: logical.green, green: logical.red, blue: logical.blue};
				2'h2: ordered = '{red: logical.green, green: logical.blue, blue: logical.red};
				default: ordered = '{red: logical.red, green: logical.blue, blue: logical.green};
			endcase
		end
		arranged = ordered;
		if (colour_pin_arrangement_r[`RPT_ARR_REVERSE]) begin
			arranged.red = rpt_rev8(ordered.red);
			arranged.green = rpt_rev8(ordered.green);
			arranged.blue = rpt_rev8(ordered.blue);
		end
	end

	// Pin registers; all update together on the pixel tick
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			colour_pins_o <= '0;
			data_enable_o <= 1'b0;
			line_sync_o <= 1'b0;
			frame_sync_o <= 1'b0;
		end else if (pix_tick) begin
			colour_pins_o <= arranged;
			data_enable_o <= de1_r;
			line_sync_o <= hs1_r;
			frame_sync_o <= vs1_r;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			panel_enable_out_o <= 1'b0;
		else if (ce_i)
			panel_enable_out_o <= panel_enable_r;
	end

	rpt_pwm u_pwm (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.freq_i(backlight_frequency_r),
		.duty_i(backlight_duty_r),
		.panel_enable_i(panel_enable_r), // Same edge as the pin, so no lone backlight cycle
		.backlight_o(backlight_o)
	);
endmodule

// *** sim/rpt_panel_props.sv ***
// Port-level assertions for the RGB panel block.
// Assumes it is bound to rpt_panel and sees only that module's ports.
`include "rpt_defs.svh"
module rpt_panel_props (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register bus
	input wire rpt_pkg::rpt_apb_req_t apb_req_i,
	input wire rpt_pkg::rpt_apb_rsp_t apb_rsp_o,
	// Panel side
	input wire logic pixel_take_o,
	input wire logic pclk_o,
	input wire logic data_enable_o,
	input wire rpt_pkg::rpt_rgb_t colour_pins_o,
	input wire logic panel_enable_out_o,
	input wire logic backlight_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import rpt_pkg::*;
	logic wr;
	logic [9:0] div_r;
	logic edge_r;
	logic skew_r;
	logic [7:0] duty_r;
	logic [3:0] quiet_r;
	assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & ce_i;
	// Shadow of the settings, so antecedents need no internal signals
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_r <= 10'h000;
			edge_r <= 1'b0;
			skew_r <= 1'b0;
			duty_r <= 8'h80;
		end else if (wr) begin
			if (apb_req_i.paddr == `RPT_OFF_PCLK_DIV) div_r <= apb_req_i.pwdata[9:0];
			if (apb_req_i.paddr == `RPT_OFF_PCLK_EDGE) edge_r <= apb_req_i.pwdata[0];
			if (apb_req_i.paddr == `RPT_OFF_SKEW) skew_r <= apb_req_i.pwdata[0];
			if (apb_req_i.paddr == `RPT_OFF_BL_DUTY) duty_r <= apb_req_i.pwdata[7:0];
		end
	end
	// Clock settings may restart the divider, so give it time to settle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) quiet_r <= 4'h0;
		else if (wr && apb_req_i.paddr <= `RPT_OFF_PCLK_EDGE) quiet_r <= 4'h0;
		else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_NO_TICK: assert property (div_r == 10'h000 && quiet_r > 4'h2 |-> !pixel_take_o && $stable(pclk_o))
		else $error("pixel clock runs with divisor zero");
	// A clock setting written inside the period may legally bend it
	AST_PCLK_RISE: assert property (quiet_r == 4'hf && div_r == 10'h003 && !edge_r && $rose(pclk_o)
		&& !apb_req_i.psel |=> !$rose(pclk_o) ##1 !$rose(pclk_o) ##1 $rose(pclk_o))
		else $error("pixel clock period wrong");
	AST_PCLK_FALL: assert property (quiet_r == 4'hf && div_r == 10'h002 && edge_r && $fell(pclk_o)
		&& !apb_req_i.psel |=> !$fell(pclk_o) ##1 $fell(pclk_o)) else $error("inverted pixel clock wrong");
	AST_DE_LAT: assert property (quiet_r == 4'hf && div_r == 10'h002 && pixel_take_o |-> ##[4:5] data_enable_o)
		else $error("data enable missing after taken pixel");
	AST_DARK: assert property (!data_enable_o && !skew_r |-> colour_pins_o == 24'h000000)
		else $error("colour driven outside visible area");
	AST_BL_PANEL: assert property (!panel_enable_out_o |-> !backlight_o)
		else $error("backlight high with panel off");
	AST_PANEL_ON: assert property (wr && apb_req_i.paddr == `RPT_OFF_LEGACY_PIN && apb_req_i.pwdata[7]
		|=> ##1 panel_enable_out_o) else $error("panel enable not set");
	AST_PANEL_OFF: assert property (wr && apb_req_i.paddr == `RPT_OFF_EXT_PIN && !apb_req_i.pwdata[15]
		|=> ##1 !panel_enable_out_o) else $error("panel enable not cleared");
	AST_DUTY_ZERO: assert property (duty_r == 8'h00 && $past(duty_r) == 8'h00 |-> !backlight_o)
		else $error("backlight high at duty zero");
	AST_DUTY_FULL: assert property (duty_r[7] && $past(duty_r[7]) && panel_enable_out_o
		&& $past(panel_enable_out_o) |-> backlight_o) else $error("backlight low at full duty");
	AST_UNMAPPED: assert property (apb_req_i.psel && apb_req_i.penable && apb_req_i.paddr > `RPT_OFF_STATUS
		|-> apb_rsp_o.pslverr) else $error("unmapped access not refused");
endmodule

bind rpt_panel rpt_panel_props u_props (.sys_clk_i, .rst_n_i, .ce_i, .apb_req_i, .apb_rsp_o, .pixel_take_o,
	.pclk_o, .data_enable_o, .colour_pins_o, .panel_enable_out_o, .backlight_o);

// *** sim/rpt_lcd_model.sv ***
// Behavioural parallel RGB panel: samples its pins once per active pixel clock edge.
// Assumes divisor of two or more, so pins are settled one system clock after that edge.
module rpt_lcd_model (
	// Clocks
	input wire logic sys_clk_i,
	input wire logic pclk_i,
	input wire logic pol_i,
	// Panel pins
	input wire logic line_sync_i,
	input wire logic frame_sync_i,
	input wire logic data_enable_i,
	input wire rpt_pkg::rpt_rgb_t pins_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import rpt_pkg::*;
	logic pclk_q = 1'b0;
	logic hs_q = 1'b0;
	logic vs_q = 1'b0;
	int cnt = 0;
	int scnt = 0;
	int vcnt = 0;
	int line_len = 0;
	int sync_len = 0;
	int vs_len = 0;
	int px_count = 0;
	rpt_rgb_t last_px = '0;
	always @(posedge sys_clk_i) begin
		pclk_q <= pclk_i;
		if (pclk_i != pclk_q && pclk_i != pol_i) begin
			hs_q <= line_sync_i;
			cnt <= cnt + 1;
			scnt <= scnt + int'(line_sync_i);
			if (data_enable_i) begin
				px_count <= px_count + 1;
				last_px <= pins_i;
			end
			if (hs_q && !line_sync_i) begin
				sync_len <= scnt;
				scnt <= 0;
			end
			// Line start taken at sync rise; frame sync counted in lines
			if (line_sync_i && !hs_q) begin
				line_len <= cnt;
				cnt <= 1;
				vs_q <= frame_sync_i;
				vcnt <= vcnt + int'(frame_sync_i);
				if (vs_q && !frame_sync_i) begin
					vs_len <= vcnt;
					vcnt <= 0;
				end
			end
		end
	end
endmodule

// *** sim/tb_rgb_panel_timing_backlight.sv ***
// Self-checking bench for the RGB panel block: APB master, pixel source, panel model.
// Assumes design, package, defs header, checker and panel model are compiled first.
`include "rpt_defs.svh"
module tb_rgb_panel_timing_backlight;
	timeunit 1ns;
	timeprecision 1ns;
	import rpt_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic edge_sel = 1'b0;
	logic ramp = 1'b0;
	rpt_apb_req_t req = '0;
	rpt_apb_rsp_t rsp;
	rpt_rgb_t pix = '0, px_set = '0;
	rpt_rgb_t pins;
	logic take, pclk, hs, vs, de, pen, bl;
	int n_errors = 0;
	int check_count = 0;
	int seed = 36306;
	int tim[10] = '{12, 6, 3, 1, 3, 5, 3, 1, 1, 2};
	int divs[3] = '{3, 5, 2};
	int bls[5][4] = '{'{1000, 32, 10000, 2500}, '{10000, 64, 1000, 500}, '{16000, 32, 1000, 250},
		'{5000, 0, 2000, 0}, '{5000, 200, 2000, 2000}};
	initial forever #50 sys_clk_i = ~sys_clk_i;
	rpt_panel DUT (.sys_clk_i, .rst_n_i, .ce_i, .apb_req_i(req), .apb_rsp_o(rsp), .pixel_i(pix),
		.pixel_take_o(take), .pclk_o(pclk), .line_sync_o(hs), .frame_sync_o(vs), .data_enable_o(de),
		.colour_pins_o(pins), .panel_enable_out_o(pen), .backlight_o(bl));
	rpt_lcd_model lcd (.sys_clk_i, .pclk_i(pclk), .pol_i(edge_sel), .line_sync_i(hs), .frame_sync_i(vs),
		.data_enable_i(de), .pins_i(pins));
	// Pixel source: set value, or ramp of equal channels stepping per taken pixel
	always @(posedge sys_clk_i) pix <= !ramp ? px_set : take ? {3{pix.green + 8'h01}} : pix;
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic ticks(int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int k;
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk_i);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			k++;
		end while (rsp.pready !== 1'b1 && k < 50);
		q = rsp.prdata;
		e = rsp.pslverr;
		if (k == 50) begin
			n_errors++;
			tally_and_finish();
		end
		req <= '0;
		@(posedge sys_clk_i);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	function automatic logic [7:0] rev8(logic [7:0] v);
		for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
	endfunction
	function automatic logic [7:0] keep(logic [7:0] v, logic [3:0] w);
		int n;
		n = (w == 4'h0 || w > 4'h8) ? 8 : int'(w);
		return v & (8'hff << (8 - n));
	endfunction
	function automatic rpt_rgb_t arrange(rpt_rgb_t p, logic [3:0] a);
		logic [7:0] r, g, b;
		r = a[0] ? rev8(p.red) : p.red;
		g = a[0] ? rev8(p.green) : p.green;
		b = a[0] ? rev8(p.blue) : p.blue;
		if (!a[3]) return a[1] ? {b, g, r} : {r, g, b};
		case (a[2:1])
			2'b00: return {b, r, g};
			2'b01: return {g, r, b};
			2'b10: return {g, b, r};
			default: return {r, b, g};
		endcase
	endfunction
	// Dithered 4-bit channel: low bits clear, at most one step up
	function automatic logic dok(logic [7:0] o, logic [7:0] v);
		return o[3:0] == 4'h0 && (o[7:4] == v[7:4] || o[7:4] == v[7:4] + 4'h1);
	endfunction
	initial begin
		logic [31:0] q, r;
		logic e, p, dq;
		rpt_rgb_t px, o;
		logic [11:0] bw;
		int hi, t0;
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		ticks(2);
		apb(1'b0, `RPT_OFF_BIT_WIDTH, 0, q, e);
		check("bit width reset", q, 32'h888);
		apb(1'b0, `RPT_OFF_BL_DUTY, 0, q, e);
		check("duty reset", q, 32'h80);
		apb(1'b0, `RPT_OFF_BL_FREQ, 0, q, e);
		check("freq reset", q, 32'hfa);
		apb(1'b1, 8'h19, 32'hffffffff, q, e);
		check("misaligned err", e, 1);
		apb(1'b0, 8'h60, 0, q, e);
		check("unmapped err", e, 1);
		check("unmapped data", q, 0);
		apb(1'b0, `RPT_OFF_STATUS, 0, q, e);
		check("status idle", q, 0);
		ce_i <= 1'b0;
		ticks(1);
		check("stalled ready", rsp.pready, 0);
		ce_i <= 1'b1;
		hi = 0;
		repeat (50) begin
			@(posedge sys_clk_i);
			hi += int'(take) + int'(pclk);
		end
		check("idle pixel clock", hi, 0);
		$display("test reset and idle done");
		for (int a = `RPT_OFF_H_TOTAL; a <= `RPT_OFF_V_SYNC1; a += 4) begin
			q = $random(seed);
			wr(8'(a), q);
			apb(1'b0, 8'(a), 0, r, e);
			check("timing reg", r, q & 32'hfff);
		end
		foreach (tim[i]) wr(8'(`RPT_OFF_H_TOTAL + 4 * i), 32'(tim[i]));
		foreach (divs[i]) begin
			wr(`RPT_OFF_PCLK_DIV, 32'(divs[i]));
			ticks(10);
			p = pclk;
			hi = 0;
			repeat (60) begin
				@(posedge sys_clk_i);
				hi += int'(pclk && !p);
				p = pclk;
			end
			check("pclk rises", hi, 60 / divs[i]);
		end
		$display("test divisor done");
		for (int s = 0; s < 2; s++) begin
			wr(`RPT_OFF_PCLK_EDGE, 32'(s));
			edge_sel <= s[0];
			ticks(300);
			hi = 0;
			dq = de;
			repeat (240) begin
				@(posedge sys_clk_i);
				if (de !== dq) hi += int'(pclk !== !s[0]);
				dq = de;
			end
			check("pclk edge", hi, 0);
			check("line length", lcd.line_len, 12);
			check("line sync", lcd.sync_len, 2);
			check("frame sync", lcd.vs_len, 1);
			t0 = lcd.px_count;
			hi = 0;
			repeat (120) begin
				@(posedge sys_clk_i);
				hi += int'(take);
			end
			check("frame pixels", hi, 18);
			check("enabled pixels", lcd.px_count - t0, 18);
		end
		$display("test timing done");
		for (int a = 0; a < 16; a++) begin
			px = 24'($random(seed));
			bw = 12'($random(seed));
			px_set <= px;
			wr(`RPT_OFF_BIT_WIDTH, 32'(bw));
			wr(`RPT_OFF_PIN_ARR, 32'(a));
			ticks(260);
			o = arrange({keep(px.red, bw[3:0]), keep(px.green, bw[7:4]), keep(px.blue, bw[11:8])}, 4'(a));
			check("pins", lcd.last_px, o);
		end
		wr(`RPT_OFF_PIN_ARR, 0);
		wr(`RPT_OFF_BIT_WIDTH, 32'h444);
		wr(`RPT_OFF_DITHER, 1);
		px = 24'($random(seed));
		px_set <= px;
		ticks(260);
		o = lcd.last_px;
		check("dither", {dok(o.red, px.red), dok(o.green, px.green), dok(o.blue, px.blue)}, 3'h7);
		wr(`RPT_OFF_DITHER, 0);
		wr(`RPT_OFF_BIT_WIDTH, 32'h888);
		ramp <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(`RPT_OFF_SKEW, 32'(k));
			ticks(260);
			hi = 0;
			repeat (240) begin
				@(posedge sys_clk_i);
				if (de && pins.red != 8'h00 && pins.blue != 8'h00)
					hi += int'(pins.red != pins.green + 8'(k) || pins.blue != pins.green - 8'(k));
			end
			check("colour skew", hi, 0);
		end
		$display("test colour done");
		wr(`RPT_OFF_LEGACY_PIN, 32'h80);
		apb(1'b0, `RPT_OFF_EXT_PIN, 0, q, e);
		check("panel bit read", q[15], 1);
		check("panel pin", pen, 1);
		foreach (bls[i]) begin
			wr(`RPT_OFF_BL_FREQ, 32'(bls[i][0]));
			wr(`RPT_OFF_BL_DUTY, 32'(bls[i][1]));
			ticks(2);
			hi = 0;
			repeat (bls[i][2]) begin
				@(posedge sys_clk_i);
				hi += int'(bl);
			end
			check("backlight high", hi, bls[i][3]);
		end
		wr(`RPT_OFF_EXT_PIN, 0);
		ticks(1);
		check("panel pin off", pen, 0);
		hi = 0;
		repeat (2000) begin
			@(posedge sys_clk_i);
			hi += int'(bl);
		end
		check("backlight off", hi, 0);
		$display("test backlight done");
		tally_and_finish();
	end
endmodule
